// *** cpf_airtime.sv ***
`timescale 1ns/10ps
module cpf_airtime (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire logic [3:0] sf_i,
    input wire logic [2:0] cr_i,
    input wire logic packing_i,
    input wire logic implicit_i,
    input wire logic crc_en_i,
    input wire logic [7:0] len_i,
    input wire logic [15:0] pre_len_i,
    output logic done_o,
    output logic [19:0] sym_x4_o
);
    import cpf_pkg::*;
    logic busy_q;
    logic [13:0] num_q;
    logic [13:0] div_q;
    logic [7:0] blk_q;
    logic [19:0] base_q;
    logic [2:0] cr_q;
    wire logic hi_sf = sf_i >= SF_HI_FIRST;
    wire logic [13:0] pos = {3'h0, len_i, 3'h0} + (crc_en_i ? CRC_BITS : 14'h0000)
        + (hi_sf ? HI_SF_EXTRA : 14'h0000) + (implicit_i ? 14'h0000 : HDR_SYMS);
    wire logic [13:0] neg = {8'h00, sf_i, 2'b00};
    wire logic [13:0] num0 = (pos > neg) ? pos - neg : 14'h0000;
    // fewer bits per symbol when packing is on at high factors
    wire logic [3:0] bits_sym = (packing_i && hi_sf) ? sf_i - 4'h2 : sf_i;
    wire logic [19:0] pre_x4 = {2'b00, pre_len_i, 2'b00};
    wire logic [7:0] ovh = hi_sf ? OVH_HI_X4 : OVH_LO_X4;
    wire logic [19:0] blk_x4 = 20'(blk_q * ({2'b00, cr_q} + 5'h04)) << 2;
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            busy_q <= 1'b0;
            done_o <= 1'b0;
            sym_x4_o <= 20'h00000;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                num_q <= num0;
                div_q <= {8'h00, bits_sym, 2'b00};
                blk_q <= 8'h00;
                cr_q <= cr_i;
                base_q <= pre_x4 + {12'h000, ovh};
                busy_q <= 1'b1;
            end else if (busy_q) begin
                // ceiling by repeated subtraction, one block per cycle
                if (num_q != 14'h0000) begin
                    num_q <= (num_q > div_q) ? num_q - div_q : 14'h0000;
                    blk_q <= blk_q + 8'h01;
                end else begin
                    busy_q <= 1'b0;
                    done_o <= 1'b1;
                    sym_x4_o <= base_q + blk_x4;
                end
            end
        end
    end
    chk_toa_floor: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(done_o) |-> sym_x4_o >= $past(base_q))
        else $error("airtime below preamble plus overhead");
endmodule : cpf_airtime

// *** cpf_frame_engine.sv ***
`timescale 1ns/10ps
// Behaviour
// - preamble defaults to twelve symbols
// - preamble length programmable from 10 to 65535
// - receive preamble search restarts each preamble period
// - frame is preamble, header, payload, optional crc
// - explicit header default, carries length, rate, crc
// - payload crc is sixteen bits
// - header always sent at rate four-eighths
// - header with failed check is discarded
// - implicit mode drops header, both ends agree
// - payload rate from header or host setting
// - symbol lasts two-to-sf chips over bandwidth
// - spreading factor five to twelve
// - symbol count is preamble, overhead, coded blocks
// - packing at sf 7 and up makes block divisor four times sf-2
// - header adds twenty bits only when explicit
// - crc adds sixteen bits only when enabled
// - rate codes one to four mean 4/5..4/8
// - scan detects preamble or data symbols
// - scan lasts 1, 2, 4, 8 or 16 symbols
// - half symbol of post-processing ends the scan
// - activity pulse only if symbols were found
// - packing carries sf minus two bits per symbol at sf 7 and up
module cpf_frame_engine (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] spreading_factor_i,
    input wire logic [3:0] css_bandwidth_sel_i,
    input wire logic [2:0] coding_rate_sel_i,
    input wire logic low_rate_symbol_packing_i,
    input wire logic implicit_hdr_i,
    input wire logic crc_en_i,
    input wire logic [7:0] pay_len_i,
    input wire logic [15:0] pre_len_i,
    input wire logic pre_len_we_i,
    input wire logic tx_start_i,
    input wire logic pay_valid_i,
    input wire logic [7:0] pay_data_i,
    output logic pay_ready_o,
    output logic tx_valid_o,
    output logic [1:0] tx_seg_o,
    output logic [2:0] tx_cr_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    output logic tx_busy_o,
    output logic toa_valid_o,
    output logic [19:0] time_on_air_x4_o,
    input wire logic rx_en_i,
    output logic rx_pre_restart_o,
    input wire logic hdr_valid_i,
    input wire logic [7:0] hdr_len_i,
    input wire logic [2:0] hdr_cr_i,
    input wire logic hdr_crc_en_i,
    input wire logic hdr_check_ok_i,
    output logic rx_hdr_accept_o,
    output logic rx_hdr_discard_o,
    output logic [7:0] rx_len_o,
    output logic [2:0] rx_cr_o,
    output logic rx_crc_en_o,
    input wire logic channel_activity_scan_start_i,
    input wire logic [2:0] scan_len_sel_i,
    input wire logic symbol_found_i,
    output logic scan_busy_o,
    output logic scan_done_o,
    output logic scan_detected_o
);
    import cpf_pkg::*;

    function automatic cpf_tx_st_t after_hdr(input logic [7:0] len, input logic crc);
        after_hdr = (len != 8'h00) ? TX_PAY : (crc ? TX_CRC : TX_IDLE);
    endfunction : after_hdr

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        crc_byte = r;
    endfunction : crc_byte

    cpf_stream_if word_s ();

    cpf_tx_st_t st_q;
    logic [15:0] pre_len_q;
    logic [15:0] cnt_q;
    logic [7:0] len_l_q;
    logic [2:0] cr_l_q;
    logic crc_l_q;
    logic impl_l_q;
    logic [15:0] crc_q;
    logic hold_v_q;
    logic [7:0] hold_q;
    logic [7:0] taken_q;
    logic [1:0] w_seg;
    logic [2:0] w_cr;
    logic [7:0] w_data;
    logic w_valid;

    // preamble length register, floored at the minimum
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pre_len_q <= PRE_LEN_RST;
        end else if (pre_len_we_i) begin
            pre_len_q <= (pre_len_i < PRE_LEN_MIN) ? PRE_LEN_MIN : pre_len_i;
        end
    end

    wire logic [3:0] sf_eff = (spreading_factor_i < SF_MIN) ? SF_MIN :
        (spreading_factor_i > SF_MAX) ? SF_MAX : spreading_factor_i;
    wire logic [7:0] hdr_b1 = {3'h0, crc_l_q, 1'b0, cr_l_q};
    wire logic [7:0] hdr_chk = len_l_q ^ hdr_b1;
    wire logic [7:0] hdr_byte = (cnt_q[1:0] == 2'h0) ? len_l_q :
        (cnt_q[1:0] == 2'h1) ? hdr_b1 : hdr_chk;
    wire logic [7:0] crc_out = (cnt_q[0] == 1'b0) ? crc_q[15:8] : crc_q[7:0];

    always_comb begin
        w_valid = 1'b1;
        w_seg = SEG_PRE;
        w_cr = cr_l_q;
        w_data = 8'h00;
        unique case (st_q)
            TX_IDLE: w_valid = 1'b0;
            TX_PRE: w_seg = SEG_PRE;
            TX_HDR: begin
                w_seg = SEG_HDR;
                w_cr = HDR_CR;
                w_data = hdr_byte;
            end
            TX_PAY: begin
                w_valid = hold_v_q;
                w_seg = SEG_PAY;
                w_data = hold_q;
            end
            TX_CRC: begin
                w_seg = SEG_CRC;
                w_data = crc_out;
            end
            default: w_valid = 1'b0;
        endcase
    end

    assign word_s.valid = w_valid;
    assign word_s.data = {w_seg, w_cr, w_data};
    wire logic push = w_valid & word_s.ready;
    wire logic pay_take = pay_valid_i & pay_ready_o;
    wire logic start_ok = tx_start_i & (st_q == TX_IDLE);
    wire logic last_pre = cnt_q == pre_len_q - 16'h0001;
    wire logic last_hdr = cnt_q[1:0] == HDR_BYTES - 2'h1;
    wire logic last_pay = cnt_q[7:0] == len_l_q - 8'h01;
    wire logic [7:0] taken_d = taken_q + {7'h00, pay_take};
    wire logic hold_busy = hold_v_q & ~(push & (st_q == TX_PAY));

    cpf_tx_st_t st_d;
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            TX_IDLE: if (start_ok) st_d = TX_PRE;
            TX_PRE: if (push && last_pre) begin
                st_d = impl_l_q ? after_hdr(len_l_q, crc_l_q) : TX_HDR;
            end
            TX_HDR: if (push && last_hdr) st_d = after_hdr(len_l_q, crc_l_q);
            TX_PAY: if (push && last_pay) st_d = crc_l_q ? TX_CRC : TX_IDLE;
            TX_CRC: if (push && cnt_q[0]) st_d = TX_IDLE;
            default: st_d = TX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            st_q <= TX_IDLE;
            cnt_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            if (st_d != st_q) begin
                cnt_q <= 16'h0000;
            end else if (push) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    // payload length, rate, crc and header mode are frozen for the whole frame
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            len_l_q <= 8'h00;
            cr_l_q <= 3'h1;
            crc_l_q <= 1'b0;
            impl_l_q <= 1'b0;
        end else if (start_ok) begin
            len_l_q <= pay_len_i;
            cr_l_q <= coding_rate_sel_i;
            crc_l_q <= crc_en_i;
            impl_l_q <= implicit_hdr_i;
        end
    end

    // one-byte hold keeps the source ready port a flop
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            hold_v_q <= 1'b0;
            taken_q <= 8'h00;
            pay_ready_o <= 1'b0;
            crc_q <= CRC_INIT;
        end else begin
            if (start_ok) begin
                taken_q <= 8'h00;
                crc_q <= CRC_INIT;
            end else begin
                taken_q <= taken_d;
            end
            if (pay_take) begin
                hold_q <= pay_data_i;
                hold_v_q <= 1'b1;
                crc_q <= crc_byte(crc_q, pay_data_i);
            end else if (push && st_q == TX_PAY) begin
                hold_v_q <= 1'b0;
            end
            pay_ready_o <= (st_d == TX_PAY) && !pay_take && !hold_busy && (taken_d < len_l_q);
        end
    end

    cpf_skid_buf u_buf (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .in_s(word_s),
        .out_valid_o(tx_valid_o),
        .out_data_o({tx_seg_o, tx_cr_o, tx_data_o}),
        .out_ready_i(tx_ready_i)
    );

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tx_busy_o <= 1'b0;
        end else begin
            tx_busy_o <= st_d != TX_IDLE;
        end
    end

    cpf_airtime u_toa (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(start_ok),
        .sf_i(sf_eff),
        .cr_i(coding_rate_sel_i),
        .packing_i(low_rate_symbol_packing_i),
        .implicit_i(implicit_hdr_i),
        .crc_en_i(crc_en_i),
        .len_i(pay_len_i),
        .pre_len_i(pre_len_q),
        .done_o(toa_valid_o),
        .sym_x4_o(time_on_air_x4_o)
    );

    // symbol timer: chip period times two to the spreading factor
    cpf_scan_st_t sc_q;
    logic [27:0] sym_cnt_q;
    logic [15:0] pre_cnt_q;
    logic [4:0] scan_cnt_q;
    logic seen_q;
    wire logic [3:0] bw_idx = (css_bandwidth_sel_i > BW_SEL_MAX) ? BW_SEL_MAX : css_bandwidth_sel_i;
    wire logic [27:0] sym_cyc = {12'h000, CHIP_CYC[bw_idx]} << sf_eff;
    wire logic [27:0] half_cyc = sym_cyc >> 1;
    wire logic scan_go = channel_activity_scan_start_i & (sc_q == SC_IDLE);
    wire logic sym_tick = sym_cnt_q == sym_cyc - 28'h0000001;
    wire logic timer_on = rx_en_i | (sc_q != SC_IDLE);
    wire logic [2:0] scan_sel = (scan_len_sel_i > SCAN_SEL_MAX) ? SCAN_SEL_MAX : scan_len_sel_i;
    wire logic [4:0] scan_syms = 5'h01 << scan_sel;
    wire logic post_end = (sc_q == SC_POST) && (sym_cnt_q >= half_cyc - 28'h0000001);

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !timer_on || scan_go || sym_tick || post_end) begin
            sym_cnt_q <= 28'h0000000;
        end else begin
            sym_cnt_q <= sym_cnt_q + 28'h0000001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !rx_en_i) begin
            pre_cnt_q <= 16'h0000;
            rx_pre_restart_o <= 1'b0;
        end else begin
            rx_pre_restart_o <= 1'b0;
            if (sym_tick) begin
                if (pre_cnt_q >= pre_len_q - 16'h0001) begin
                    pre_cnt_q <= 16'h0000;
                    rx_pre_restart_o <= 1'b1;
                end else begin
                    pre_cnt_q <= pre_cnt_q + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sc_q <= SC_IDLE;
            scan_cnt_q <= 5'h00;
            seen_q <= 1'b0;
            scan_busy_o <= 1'b0;
            scan_done_o <= 1'b0;
            scan_detected_o <= 1'b0;
        end else begin
            scan_done_o <= 1'b0;
            scan_detected_o <= 1'b0;
            unique case (sc_q)
                SC_IDLE: if (scan_go) begin
                    sc_q <= SC_RUN;
                    scan_cnt_q <= 5'h00;
                    seen_q <= 1'b0;
                    scan_busy_o <= 1'b1;
                end
                SC_RUN: begin
                    seen_q <= seen_q | symbol_found_i;
                    if (sym_tick) begin
                        scan_cnt_q <= scan_cnt_q + 5'h01;
                        if (scan_cnt_q == scan_syms - 5'h01) sc_q <= SC_POST;
                    end
                end
                SC_POST: if (post_end) begin
                    sc_q <= SC_IDLE;
                    scan_busy_o <= 1'b0;
                    scan_done_o <= 1'b1;
                    scan_detected_o <= seen_q;
                end
                default: sc_q <= SC_IDLE;
            endcase
        end
    end

    // header received: implicit mode takes host settings instead
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rx_hdr_accept_o <= 1'b0;
            rx_hdr_discard_o <= 1'b0;
            rx_len_o <= 8'h00;
            rx_cr_o <= 3'h1;
            rx_crc_en_o <= 1'b0;
        end else begin
            rx_hdr_accept_o <= 1'b0;
            rx_hdr_discard_o <= 1'b0;
            if (implicit_hdr_i) begin
                rx_len_o <= pay_len_i;
                rx_cr_o <= coding_rate_sel_i;
                rx_crc_en_o <= crc_en_i;
            end else if (hdr_valid_i) begin
                if (hdr_check_ok_i) begin
                    rx_hdr_accept_o <= 1'b1;
                    rx_len_o <= hdr_len_i;
                    rx_cr_o <= hdr_cr_i;
                    rx_crc_en_o <= hdr_crc_en_i;
                end else begin
                    rx_hdr_discard_o <= 1'b1;
                end
            end
        end
    end

    sequence hdr_bad_s;
        hdr_valid_i && !hdr_check_ok_i && !implicit_hdr_i;
    endsequence
    sequence discard_s;
        rx_hdr_discard_o && !rx_hdr_accept_o;
    endsequence

    chk_pre_default: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $fell(sys_rst_i) |-> pre_len_q == PRE_LEN_RST)
        else $error("preamble length not twelve after reset");
    chk_pre_floor: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        pre_len_we_i |=> pre_len_q >= PRE_LEN_MIN && pre_len_q >= $past(pre_len_i))
        else $error("preamble length below floor");
    chk_frame_order: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(st_q == TX_PAY) |-> $past(st_q) == TX_PRE || $past(st_q) == TX_HDR)
        else $error("payload not after preamble or header");
    chk_hdr_rate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        tx_valid_o && tx_seg_o == SEG_HDR |-> tx_cr_o == HDR_CR)
        else $error("header not at strongest rate");
    chk_implicit_nohdr: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        impl_l_q && st_q == TX_PRE && push && last_pre |=> st_q != TX_HDR)
        else $error("header sent in implicit mode");
    chk_crc_only_en: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        st_q == TX_CRC |-> crc_l_q)
        else $error("crc sent while disabled");
    chk_hdr_discard: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        hdr_bad_s |=> discard_s)
        else $error("bad header not discarded");
    chk_restart_period: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        rx_pre_restart_o |-> $past(sym_tick) && $past(pre_cnt_q) >= $past(pre_len_q) - 16'h0001)
        else $error("preamble restart off period");
    chk_scan_end: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        scan_done_o |-> $past(sc_q) == SC_POST && !scan_busy_o)
        else $error("scan ended without post phase");
    chk_scan_flag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        scan_detected_o |-> scan_done_o && $past(seen_q))
        else $error("activity flagged without symbols");
endmodule : cpf_frame_engine

// *** cpf_frame_engine_bench.sv ***
`timescale 1ns/10ps
module cpf_frame_engine_bench;
    import cpf_pkg::*;
    logic clk = 1'h0, rst = 1'h1, ldr = 1'h0, impl = 1'h0, crc = 1'h1, pwe = 1'h0;
    logic start = 1'h0, hv = 1'h0, hok = 1'h0, scs = 1'h0, found = 1'h0, slow = 1'h0;
    logic clr = 1'h1;
    logic rxe = 1'h0;
    logic [3:0] sf = 4'h7, bw = 4'h9;
    logic [2:0] cr = 3'h1, sel = 3'h0, hcr = 3'h0, txcr, rcr;
    logic [7:0] len = 8'h02, txd, rlen;
    logic [15:0] pre = 16'h0000;
    logic [15:0] cnt [4];
    logic [1:0] seg;
    logic [19:0] time_on_air;
    logic prdy, txv, busy, toav, rst_p, acc, dis, rcrc, sbusy, sdone, sdet, rdy, bad;
    int fail_count = 0;
    int n_tests = 0;
    int k;
    always #5 clk = ~clk;
    cpf_frame_engine u_dut (.sys_clk_i(clk), .sys_rst_i(rst), .spreading_factor_i(sf),
        .css_bandwidth_sel_i(bw), .coding_rate_sel_i(cr), .low_rate_symbol_packing_i(ldr),
        .implicit_hdr_i(impl), .crc_en_i(crc), .pay_len_i(len), .pre_len_i(pre),
        .pre_len_we_i(pwe), .tx_start_i(start), .pay_valid_i(1'h1), .pay_data_i(8'h5A),
        .pay_ready_o(prdy), .tx_valid_o(txv), .tx_seg_o(seg), .tx_cr_o(txcr),
        .tx_data_o(txd), .tx_ready_i(rdy), .tx_busy_o(busy), .toa_valid_o(toav),
        .time_on_air_x4_o(time_on_air), .rx_en_i(rxe), .rx_pre_restart_o(rst_p), .hdr_valid_i(hv),
        .hdr_len_i(len), .hdr_cr_i(hcr), .hdr_crc_en_i(crc), .hdr_check_ok_i(hok),
        .rx_hdr_accept_o(acc), .rx_hdr_discard_o(dis), .rx_len_o(rlen), .rx_cr_o(rcr),
        .rx_crc_en_o(rcrc), .channel_activity_scan_start_i(scs), .scan_len_sel_i(sel),
        .symbol_found_i(found), .scan_busy_o(sbusy), .scan_done_o(sdone),
        .scan_detected_o(sdet));
    cpf_peer_rx u_peer (.sys_clk_i(clk), .clr_i(clr), .slow_i(slow), .tx_valid_i(txv),
        .tx_seg_i(seg), .tx_cr_i(txcr), .tx_data_i(txd), .tx_ready_o(rdy), .cnt_o(cnt),
        .bad_o(bad));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic wait_on(ref logic s, input logic v, input int lim, output int n);
        for (n = 1; n < lim && s !== v; n++) step(1);
        if (s !== v) begin
            fail_count++;
            $display("[ERR] %0t wait ran out", $time);
            end_of_test();
        end
    endtask : wait_on
    task automatic frame(input logic [3:0] s, input logic [2:0] c, input logic im,
        input logic cn, input logic [7:0] n, input logic [15:0] np, input logic [19:0] t);
        sf = s; cr = c; impl = im; crc = cn; len = n; clr = 1'h1;
        step(1);
        clr = 1'h0; start = 1'h1;
        step(1);
        start = 1'h0;
        wait_on(toav, 1'h1, 400, k);
        chk(time_on_air, t);
        wait_on(busy, 1'h0, 4000, k);
        // busy drops before the two-entry buffer has drained
        wait_on(txv, 1'h0, 8, k);
        chk(cnt[0], np);
        chk(cnt[1], im ? 32'h0 : 32'h3);
        chk(cnt[2], n);
        chk(cnt[3], cn ? 2 : 0);
        chk(bad, 1'h0);
        $display("frame test done");
    endtask : frame
    task automatic scan(input logic f, input logic [2:0] s, input int exp);
        sel = s; found = f; scs = 1'h1;
        step(1);
        scs = 1'h0;
        chk(sbusy, 1'h1);
        wait_on(sdone, 1'h1, 60000, k);
        chk(sdet, f);
        chk(sbusy, 1'h0);
        chk(k > exp - 9 && k < exp + 9, 1'h1);
        $display("scan test done");
    endtask : scan
    initial begin
        step(6);
        rst = 1'h0;
        frame(4'h7, 3'h1, 1'h0, 1'h1, 8'h02, 16'h000C, 20'h00089);
        slow = 1'h1; pre = 16'h0005; pwe = 1'h1;
        step(1);
        pwe = 1'h0;
        frame(4'h5, 3'h4, 1'h1, 1'h0, 8'h01, 16'h000A, 20'h00061);
        slow = 1'h0; ldr = 1'h1;
        frame(4'hC, 3'h4, 1'h0, 1'h1, 8'h14, 16'h000A, 20'h000D9);
        ldr = 1'h0; impl = 1'h0; hcr = 3'h3; hv = 1'h1;
        step(1);
        hv = 1'h0;
        wait_on(dis, 1'h1, 4, k);
        chk(acc, 1'h0);
        step(1);
        hok = 1'h1; hv = 1'h1;
        step(1);
        hv = 1'h0;
        wait_on(acc, 1'h1, 4, k);
        step(1);
        chk(rcr, 3'h3);
        chk(rlen, 8'h14);
        chk(rcrc, 1'h1);
        impl = 1'h1; cr = 3'h2;
        step(2);
        chk(rcr, 3'h2);
        $display("header test done");
        sf = 4'h5;
        scan(1'h1, 3'h0, 9600);
        scan(1'h0, 3'h1, 16000);
        // receive search shares the transmit preamble length, ten symbols
        rxe = 1'h1;
        wait_on(rst_p, 1'h1, 66000, k);
        chk(k > 63991 && k < 64009, 1'h1);
        $display("restart test done");
        end_of_test();
    end
endmodule : cpf_frame_engine_bench

// *** cpf_peer_rx.sv ***
`timescale 1ns/10ps
module cpf_peer_rx #(
    parameter logic [7:0] PAY_BYTE = 8'h5A
) (
    input wire logic sys_clk_i,
    input wire logic clr_i,
    input wire logic slow_i,
    input wire logic tx_valid_i,
    input wire logic [1:0] tx_seg_i,
    input wire logic [2:0] tx_cr_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    output logic [15:0] cnt_o [4],
    output logic bad_o
);
    logic [1:0] last_q;
    logic tog_q;
    // slow mode stalls every other cycle
    assign tx_ready_o = !slow_i || tog_q;
    always_ff @(posedge sys_clk_i) begin
        tog_q <= clr_i ? 1'h0 : !tog_q;
        if (clr_i) begin
            cnt_o <= '{default: 16'h0000};
            last_q <= 2'h0;
            bad_o <= 1'h0;
        end else if (tx_valid_i && tx_ready_o) begin
            cnt_o[tx_seg_i] <= cnt_o[tx_seg_i] + 16'h0001;
            last_q <= tx_seg_i;
            if (tx_seg_i < last_q) bad_o <= 1'h1;
            if (tx_seg_i == 2'h1 && tx_cr_i != 3'h4) bad_o <= 1'h1;
            if (tx_seg_i == 2'h2 && tx_data_i != PAY_BYTE) bad_o <= 1'h1;
        end
    end
endmodule : cpf_peer_rx

// *** cpf_pkg.sv ***
package cpf_pkg;
    localparam int CLK_MHZ = 100;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam logic [15:0] PRE_LEN_RST = 16'h000C;
    localparam logic [15:0] PRE_LEN_MIN = 16'h000A;
    localparam logic [3:0] SF_MIN = 4'h5;
    localparam logic [3:0] SF_MAX = 4'hC;
    localparam logic [3:0] SF_HI_FIRST = 4'h7;
    localparam logic [13:0] HDR_SYMS = 14'h0014;
    localparam logic [13:0] CRC_BITS = 14'h0010;
    localparam logic [13:0] HI_SF_EXTRA = 14'h0008;
    localparam logic [7:0] OVH_LO_X4 = 8'h39;
    localparam logic [7:0] OVH_HI_X4 = 8'h31;
    localparam logic [2:0] HDR_CR = 3'h4;
    localparam logic [1:0] HDR_BYTES = 2'h3;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [2:0] SCAN_SEL_MAX = 3'h4;
    localparam logic [3:0] BW_SEL_MAX = 4'h9;
    localparam int WORD_W = 13;
    // chip period in clock cycles per bandwidth code, rounded
    localparam logic [15:0] CHIP_CYC [10] = '{
        16'h3204, 16'h257D, 16'h18FE, 16'h12C0, 16'h0C80,
        16'h095F, 16'h0640, 16'h0320, 16'h0190, 16'h00C8
    };
    typedef enum logic [1:0] {
        SEG_PRE = 2'b00,
        SEG_HDR = 2'b01,
        SEG_PAY = 2'b10,
        SEG_CRC = 2'b11
    } cpf_seg_t;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_PRE = 3'b001,
        TX_HDR = 3'b010,
        TX_PAY = 3'b011,
        TX_CRC = 3'b100
    } cpf_tx_st_t;
    typedef enum logic [1:0] {
        SC_IDLE = 2'b00,
        SC_RUN = 2'b01,
        SC_POST = 2'b10
    } cpf_scan_st_t;
endpackage : cpf_pkg

// *** cpf_skid_buf.sv ***
`timescale 1ns/10ps
module cpf_skid_buf (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    cpf_stream_if.snk in_s,
    output logic out_valid_o,
    output logic [cpf_pkg::WORD_W-1:0] out_data_o,
    input wire logic out_ready_i
);
    import cpf_pkg::*;
    logic head_v_q;
    logic tail_v_q;
    logic [WORD_W-1:0] head_q;
    logic [WORD_W-1:0] tail_q;
    wire logic pop = head_v_q & out_ready_i;
    // tail full blocks the writer, so push and a full tail never meet
    wire logic push = in_s.valid & ~tail_v_q;
    assign in_s.ready = ~tail_v_q;
    assign out_valid_o = head_v_q;
    assign out_data_o = head_q;
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            head_v_q <= 1'b0;
            tail_v_q <= 1'b0;
        end else if (tail_v_q) begin
            if (pop) begin
                head_q <= tail_q;
                tail_v_q <= 1'b0;
            end
        end else if (push) begin
            if (!head_v_q || pop) begin
                head_q <= in_s.data;
                head_v_q <= 1'b1;
            end else begin
                tail_q <= in_s.data;
                tail_v_q <= 1'b1;
            end
        end else if (pop) begin
            head_v_q <= 1'b0;
        end
    end
endmodule : cpf_skid_buf

// *** cpf_stream_if.sv ***
`timescale 1ns/10ps
interface cpf_stream_if;
    import cpf_pkg::*;
    logic valid;
    logic ready;
    logic [WORD_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : cpf_stream_if
